// ===== verilog/dfs_dest_fifo.sv
// destination-fifo slot register set with write address sequencer
// assumes apb master on pclk and a channel controller on the same clock
`timescale 1ns/100ps
`default_nettype none
module dfs_dest_fifo
  import dfs_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // transfer request from channel controller
  input  wire logic        tr_valid,
  input  wire logic        tr_slot,
  input  wire logic [31:0] tr_options,
  input  wire logic [31:0] tr_dst_addr,
  input  wire logic [15:0] tr_first_dim_byte_count,
  input  wire logic [15:0] tr_bcnt,
  input  wire logic [15:0] tr_dst_bidx,
  output logic             tr_ready,
  // write commands
  output logic             wr_valid,
  output logic      [31:0] wr_addr,
  input  wire logic        wr_ready,
  // completion report
  output logic             done_valid,
  output logic       [5:0] done_code,
  output logic             done_chain,
  output logic             done_irq,
  // interrupt
  output logic             irq
);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] fw_mask(input logic [2:0] code);
    unique case (code)
      FW_8:    fw_mask = 16'h0000;
      FW_16:   fw_mask = 16'h0001;
      FW_32:   fw_mask = 16'h0003;
      FW_64:   fw_mask = 16'h0007;
      FW_128:  fw_mask = 16'h000f;
      default: fw_mask = 16'h0000;
    endcase
  endfunction

  function automatic logic [31:0] step_addr(input logic [31:0] base,
                                             input logic [15:0] ofs,
                                             input logic [31:0] opt);
    logic [15:0] o;
    o = ofs;
    if (opt[OPT_DAM_BIT])
      o = ofs & fw_mask(opt[OPT_FW_LO +: 3]);
    step_addr = base + {16'h0000, o};
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dfs_state_t  state_reg,    state_next;
  logic [31:0] opt_reg      [NUM_SLOTS];
  logic [31:0] opt_next     [NUM_SLOTS];
  logic        cur_reg,      cur_next;
  logic [31:0] ref_reg,      ref_next;
  logic [31:0] daddr_reg,    daddr_next;
  logic [15:0] first_dim_byte_count_reg,     first_dim_byte_count_next;
  logic [15:0] arld_reg,     arld_next;
  logic [15:0] bcnt_reg,     bcnt_next;
  logic [15:0] bidx_reg,     bidx_next;
  logic [15:0] ofs_reg,      ofs_next;
  logic        wrv_reg,      wrv_next;
  logic [31:0] wra_reg,      wra_next;
  logic        done_reg,     done_next;
  logic [5:0]  code_reg,     code_next;
  logic        dch_reg,      dch_next;
  logic        dirq_reg,     dirq_next;
  logic        trr_reg,      trr_next;
  logic [1:0]  stat_reg,     stat_next;
  logic [1:0]  mask_reg,     mask_next;
  logic        irq_reg,      irq_next;
  logic [31:0] rdata_reg,    rdata_next;
  logic        rdy_reg,      rdy_next;
  logic        err_reg,      err_next;
  logic        accept;
  logic        wr_fire;
  logic        apb_wr;
  logic [31:0] opt_cur;
  logic [1:0]  ev;

  assign accept  = tr_valid && trr_reg;
  assign wr_fire = wrv_reg && wr_ready;
  assign apb_wr  = psel && penable && pwrite && rdy_reg && !err_reg;
  assign opt_cur = opt_reg[cur_reg];

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      opt_next[i] = opt_reg[i];
    end
    cur_next   = cur_reg;
    ref_next   = ref_reg;
    daddr_next = daddr_reg;
    first_dim_byte_count_next  = first_dim_byte_count_reg;
    arld_next  = arld_reg;
    bcnt_next  = bcnt_reg;
    bidx_next  = bidx_reg;
    ofs_next   = ofs_reg;
    wrv_next   = wrv_reg;
    wra_next   = wra_reg;
    done_next  = 1'b0;
    code_next  = code_reg;
    dch_next   = 1'b0;
    dirq_next  = 1'b0;
    mask_next  = mask_reg;
    ev         = 2'b00;
    // software write to the writable option fields
    if (apb_wr && (paddr == OFS_OPT0 || paddr == OFS_OPT1)) begin
      opt_next[paddr[2]] = pwdata & OPT_RW_MASK;
    end
    if (apb_wr && paddr == OFS_MASK) begin
      mask_next = pwdata[1:0];
    end
    unique case (state_reg)
      DFS_IDLE: begin
        if (accept) begin
          opt_next[tr_slot] = tr_options & OPT_RW_MASK;
          cur_next   = tr_slot;
          ref_next   = tr_dst_addr;
          first_dim_byte_count_next  = tr_first_dim_byte_count;
          arld_next  = tr_first_dim_byte_count;
          bcnt_next  = tr_bcnt;
          bidx_next  = tr_dst_bidx;
          ofs_next   = 16'h0000;
          wrv_next   = 1'b1;
          wra_next   = tr_dst_addr;
          state_next = DFS_RUN;
          if (tr_options[OPT_FW_LO +: 3] > FW_128) begin
            ev[ST_BADFW_BIT] = 1'b1;
          end
        end
      end
      DFS_RUN: begin
        if (wr_fire) begin
          daddr_next = wra_reg;
          if (first_dim_byte_count_reg <= 16'h0001) begin
            // array serviced: reload count, advance reference unless last array
            first_dim_byte_count_next = arld_reg;
            ofs_next  = 16'h0000;
            // reference stays on the last array once done
            if (bcnt_reg <= 16'h0001) begin
              bcnt_next  = 16'h0000;
              wrv_next   = 1'b0;
              state_next = DFS_IDLE;
              done_next  = 1'b1;
              code_next  = opt_cur[OPT_CODE_LO +: 6];
              dch_next   = opt_cur[OPT_CHAIN_BIT];
              dirq_next  = opt_cur[OPT_IRQ_BIT];
              ev[ST_DONE_BIT] = 1'b1;
            end else begin
              bcnt_next = bcnt_reg - 16'h0001;
              ref_next  = ref_reg + {{16{bidx_reg[15]}}, bidx_reg};
              wra_next  = ref_reg + {{16{bidx_reg[15]}}, bidx_reg};
            end
          end else begin
            first_dim_byte_count_next = first_dim_byte_count_reg - 16'h0001;
            ofs_next  = ofs_reg + 16'h0001;
            // width only matters in constant mode
            wra_next  = step_addr(ref_reg, ofs_reg + 16'h0001,
                                  opt_cur);
          end
        end
      end
    endcase
    trr_next = (state_next == DFS_IDLE);
    // sticky status, set wins over write-one-to-clear
    stat_next = stat_reg;
    if (apb_wr && paddr == OFS_STATUS) begin
      stat_next = stat_reg & ~pwdata[1:0];
    end
    stat_next = stat_next | ev;
    irq_next  = |(stat_next & mask_next);
  end

  // ------------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------------
  always_comb begin
    rdy_next   = psel && !penable;
    err_next   = 1'b0;
    rdata_next = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_SRC_REF:  rdata_next = 32'h00000000;
        OFS_DST_REF:  rdata_next = ref_reg;
        OFS_STATUS:   rdata_next = {30'h0, stat_reg};
        OFS_MASK:     rdata_next = {30'h0, mask_reg};
        OFS_OPT0:     rdata_next = opt_reg[0] & OPT_RW_MASK;
        OFS_OPT1:     rdata_next = opt_reg[1] & OPT_RW_MASK;
        OFS_SRC0:     rdata_next = 32'h00000000;
        OFS_SRC1:     rdata_next = 32'h00000000;
        OFS_DST_ADDR: rdata_next = daddr_reg;
        default:      err_next   = 1'b1;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= DFS_IDLE;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        opt_reg[i] <= OPT_RESET;
      end
      cur_reg   <= 1'b0;
      ref_reg   <= 32'h00000000;
      daddr_reg <= 32'h00000000;
      first_dim_byte_count_reg  <= 16'h0000;
      arld_reg  <= 16'h0000;
      bcnt_reg  <= 16'h0000;
      bidx_reg  <= 16'h0000;
      ofs_reg   <= 16'h0000;
      wrv_reg   <= 1'b0;
      wra_reg   <= 32'h00000000;
      done_reg  <= 1'b0;
      code_reg  <= 6'h00;
      dch_reg   <= 1'b0;
      dirq_reg  <= 1'b0;
      trr_reg   <= 1'b1;
      stat_reg  <= 2'h0;
      mask_reg  <= 2'h0;
      irq_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
      rdy_reg   <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        opt_reg[i] <= opt_next[i];
      end
      cur_reg   <= cur_next;
      ref_reg   <= ref_next;
      daddr_reg <= daddr_next;
      first_dim_byte_count_reg  <= first_dim_byte_count_next;
      arld_reg  <= arld_next;
      bcnt_reg  <= bcnt_next;
      bidx_reg  <= bidx_next;
      ofs_reg   <= ofs_next;
      wrv_reg   <= wrv_next;
      wra_reg   <= wra_next;
      done_reg  <= done_next;
      code_reg  <= code_next;
      dch_reg   <= dch_next;
      dirq_reg  <= dirq_next;
      trr_reg   <= trr_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
      rdata_reg <= rdata_next;
      rdy_reg   <= rdy_next;
      err_reg   <= err_next;
    end
  end

  assign prdata     = rdata_reg;
  assign pready     = rdy_reg;
  assign pslverr    = err_reg;
  assign tr_ready   = trr_reg;
  assign wr_valid   = wrv_reg;
  assign wr_addr    = wra_reg;
  assign done_valid = done_reg;
  assign done_code  = code_reg;
  assign done_chain = dch_reg;
  assign done_irq   = dirq_reg;
  assign irq        = irq_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_src_ref_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && (paddr == OFS_SRC_REF || paddr == OFS_SRC0
      || paddr == OFS_SRC1) |=> prdata == 32'h0)
    else $error("source field read nonzero");

  a_ref_on_accept: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> ref_reg == $past(tr_dst_addr) && wr_addr == ref_reg)
    else $error("reference not loaded on accept");

  a_ref_hold: assert property (@(posedge pclk) disable iff (!presetn)
    done_valid |-> ref_reg == $past(ref_reg))
    else $error("reference moved at completion");

  a_chain_report: assert property (@(posedge pclk) disable iff (!presetn)
    done_valid |-> done_chain == opt_cur[OPT_CHAIN_BIT])
    else $error("chain enable not reported");

  a_irq_report: assert property (@(posedge pclk) disable iff (!presetn)
    done_valid |-> done_irq == opt_cur[OPT_IRQ_BIT])
    else $error("interrupt enable not reported");

  a_code_report: assert property (@(posedge pclk) disable iff (!presetn)
    done_valid |-> done_code == opt_cur[OPT_CODE_LO +: 6]
      && state_reg == DFS_IDLE)
    else $error("completion code mismatch");

  a_const_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wr_valid && state_reg == DFS_RUN && opt_cur[OPT_DAM_BIT]
      |-> (wr_addr - ref_reg) <= {16'h0, fw_mask(opt_cur[10:8])})
    else $error("constant mode address left fifo width");

  a_incrementing_mode_step: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && !opt_cur[OPT_DAM_BIT] && first_dim_byte_count_reg > 16'h1
      |=> wr_addr == $past(wr_addr) + 32'h1)
    else $error("increment mode did not step");

  a_count_reload: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire && first_dim_byte_count_reg <= 16'h1 && bcnt_reg > 16'h1
      |=> first_dim_byte_count_reg == arld_reg)
    else $error("byte count not reloaded");

  a_last_addr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_fire |=> daddr_reg == $past(wr_addr))
    else $error("last write address not held");

  a_badfw_flag: assert property (@(posedge pclk) disable iff (!presetn)
    accept && tr_options[10:8] > FW_128
      |=> stat_reg[ST_BADFW_BIT])
    else $error("reserved width not flagged");

  a_opt_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (opt_reg[0] & ~OPT_RW_MASK) == 32'h0
      && (opt_reg[1] & ~OPT_RW_MASK) == 32'h0)
    else $error("reserved option bits set");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(stat_reg & mask_reg))
    else $error("interrupt level mismatch");
endmodule // dfs_dest_fifo
`default_nettype wire

// ===== shared/dfs_pkg.sv
// constants and register map of the destination-fifo slot register set
// assumes one apb slave clock shared with the channel controller
package dfs_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_SRC_REF   = 8'h00;
  localparam logic [7:0] OFS_DST_REF   = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_MASK      = 8'h0c;
  localparam logic [7:0] OFS_OPT0      = 8'h10;
  localparam logic [7:0] OFS_OPT1      = 8'h14;
  localparam logic [7:0] OFS_SRC0      = 8'h18;
  localparam logic [7:0] OFS_SRC1      = 8'h1c;
  localparam logic [7:0] OFS_DST_ADDR  = 8'h20;
  // ------------------------------------------------------------------
  // options fields
  // ------------------------------------------------------------------
  localparam int         OPT_CHAIN_BIT = 22;
  localparam int         OPT_IRQ_BIT   = 20;
  localparam int         OPT_CODE_LO   = 12;
  localparam int         OPT_FW_LO     = 8;
  localparam int         OPT_PRI_LO    = 4;
  localparam int         OPT_DAM_BIT   = 1;
  localparam int         OPT_SAM_BIT   = 0;
  localparam logic [31:0] OPT_RW_MASK  = 32'h0053f773;
  localparam logic [31:0] OPT_RESET    = 32'h00000000;
  // ------------------------------------------------------------------
  // fifo width codes and status bits
  // ------------------------------------------------------------------
  localparam logic [2:0] FW_8          = 3'h0;
  localparam logic [2:0] FW_16         = 3'h1;
  localparam logic [2:0] FW_32         = 3'h2;
  localparam logic [2:0] FW_64         = 3'h3;
  localparam logic [2:0] FW_128        = 3'h4;
  localparam int         ST_DONE_BIT   = 0;
  localparam int         ST_BADFW_BIT  = 1;
  localparam int         NUM_SLOTS     = 2;
  typedef enum logic {DFS_IDLE, DFS_RUN} dfs_state_t;
endpackage

// ===== testbench/dfs_chan_model.sv
// channel controller model: submits transfer requests, takes write commands
// assumes the destination-fifo slot block on the same pclk
`timescale 1ns/100ps
`default_nettype none
module dfs_chan_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // stall control
  input  wire logic        slow_mode,
  // transfer request
  output logic             tr_valid,
  output logic             tr_slot,
  output logic      [31:0] tr_options,
  output logic      [31:0] tr_dst_addr,
  output logic      [15:0] tr_first_dim_byte_count,
  output logic      [15:0] tr_bcnt,
  output logic      [15:0] tr_dst_bidx,
  input  wire logic        tr_ready,
  // write command sink
  output logic             wr_ready
);
  initial begin
    tr_valid = 1'b0;
    tr_slot = 1'b0;
    tr_options = 32'h0;
    tr_dst_addr = 32'h0;
    tr_first_dim_byte_count = 16'h0;
    tr_bcnt = 16'h0;
    tr_dst_bidx = 16'h0;
    wr_ready = 1'b0;
  end
  // ------------------------------------------------------------------
  // write sink, stalls every other cycle when slow
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    wr_ready <= !presetn ? 1'b0 : (slow_mode ? ~wr_ready : 1'b1);
  end
  // ------------------------------------------------------------------
  // request held until taken, then fields scrambled
  // ------------------------------------------------------------------
  task automatic submit(input logic s, input logic [31:0] o, d,
                        input logic [15:0] a, b, x);
    @(posedge pclk);
    tr_valid <= 1'b1;
    tr_slot <= s;
    tr_options <= o;
    tr_dst_addr <= d;
    tr_first_dim_byte_count <= a;
    tr_bcnt <= b;
    tr_dst_bidx <= x;
    do @(posedge pclk); while (tr_ready !== 1'b1);
    tr_valid <= 1'b0;
    tr_slot <= ~s;
    tr_options <= ~o;
    tr_dst_addr <= ~d;
    tr_first_dim_byte_count <= ~a;
    tr_bcnt <= ~b;
    tr_dst_bidx <= ~x;
  endtask
endmodule // dfs_chan_model
`default_nettype wire

// ===== testbench/tb.sv
// testbench of the destination-fifo slot register set
// assumes apb master here and the channel controller model beside it
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dfs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, wr_addr, r, tr_options, tr_dst_addr;
  logic tr_valid, tr_slot, tr_ready, wr_valid, wr_ready, irq, e;
  logic done_valid, done_chain, done_irq;
  logic [5:0] done_code;
  logic [15:0] tr_first_dim_byte_count, tr_bcnt, tr_dst_bidx;
  logic [31:0] got_q[$];
  int fail_count, n_checks, cyc;
  dfs_dest_fifo u_dfs_dest_fifo (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tr_valid(tr_valid), .tr_slot(tr_slot), .tr_options(tr_options),
    .tr_dst_addr(tr_dst_addr), .tr_first_dim_byte_count(tr_first_dim_byte_count), .tr_bcnt(tr_bcnt),
    .tr_dst_bidx(tr_dst_bidx), .tr_ready(tr_ready), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_ready(wr_ready), .done_valid(done_valid),
    .done_code(done_code), .done_chain(done_chain), .done_irq(done_irq),
    .irq(irq));
  dfs_chan_model u_dfs_chan_model (.pclk(pclk), .presetn(presetn),
    .slow_mode(slow), .tr_valid(tr_valid), .tr_slot(tr_slot),
    .tr_options(tr_options), .tr_dst_addr(tr_dst_addr),
    .tr_first_dim_byte_count(tr_first_dim_byte_count), .tr_bcnt(tr_bcnt), .tr_dst_bidx(tr_dst_bidx),
    .tr_ready(tr_ready), .wr_ready(wr_ready));
  // ------------------------------------------------------------------
  // clock, timeout, write command capture
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_addr);
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ------------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
    chk({31'h0, e}, 32'h0);
  endtask
  // one request, its write addresses, completion and read-back
  task automatic run(input logic s, input logic [31:0] o, d,
                     input logic [15:0] a, b, x);
    int wb, k;
    logic [31:0] ex, base;
    wb = (o[10:8] <= 3'h4) ? (1 << o[10:8]) : 1;
    k = 0;
    got_q.delete();
    u_dfs_chan_model.submit(s, o, d, a, b, x);
    for (int t = 0; t < 400 && done_valid !== 1'b1; t++) @(posedge pclk);
    chk({31'h0, done_valid}, 32'h1);
    chk({26'h0, done_code}, {26'h0, o[17:12]});
    chk({31'h0, done_chain}, {31'h0, o[22]});
    chk({31'h0, done_irq}, {31'h0, o[20]});
    chk(32'(got_q.size()), 32'(a) * 32'(b));
    for (int bi = 0; bi < int'(b); bi++) begin
      base = d + 32'(bi) * {{16{x[15]}}, x};
      for (int i = 0; i < int'(a); i++) begin
        ex = base + 32'(o[1] ? (i & (wb - 1)) : i);
        chk(got_q[k], ex);
        k++;
      end
    end
    rd(OFS_DST_REF, base);
    rd(OFS_DST_ADDR, ex);
    rd(s ? OFS_OPT1 : OFS_OPT0, o & OPT_RW_MASK);
  endtask
  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    presetn = 1'b0;
    slow = 1'b0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_OPT0, OPT_RESET);
    rd(OFS_SRC_REF, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, OFS_OPT0, 32'hffffffff);
    rd(OFS_OPT0, OPT_RW_MASK);
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, OFS_OPT1, 32'(p) << OPT_PRI_LO);
      rd(OFS_OPT1, 32'(p) << OPT_PRI_LO);
    end
    apb(1'b1, OFS_SRC_REF, 32'hffffffff);
    rd(OFS_SRC_REF, 32'h0);
    slow <= 1'b1;
    run(1'b0, 32'h0052a030, 32'h00001000, 16'h2, 16'h3, 16'hfff0);
    slow <= 1'b0;
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, OFS_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rd(OFS_STATUS, 32'h0);
    run(1'b1, 32'h00000000, 32'h00000020, 16'h1, 16'h1, 16'h0);
    for (int w = 0; w < 6; w++) begin
      run(1'b1, (32'(w) << OPT_FW_LO) | (32'(w) << OPT_CODE_LO) | 32'h2,
          32'h00003000, 16'(2 << (w < 5 ? w : 0)), 16'h2, 16'h0040);
    end
    run(1'b0, 32'h00000101, 32'h00004000, 16'h4, 16'h1, 16'h0);
    rd(OFS_STATUS, 32'h3);
    rd(OFS_SRC0, 32'h0);
    rd(OFS_SRC1, 32'h0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
